// ---- iod_pkg.sv ----
// iod_pkg.sv: constants and types for the inertial output data registers
`default_nettype none
package iod_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned SAMPLE_W = 32;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned NUM_AXES = 4;
	// word addresses of the output registers (read only, no flash backup)
	localparam logic [6:0] ADDR_RATE_X_LOW = 7'h04;
	localparam logic [6:0] ADDR_RATE_X_HIGH = 7'h06;
	localparam logic [6:0] ADDR_RATE_Y_LOW = 7'h08;
	localparam logic [6:0] ADDR_RATE_Y_HIGH = 7'h0A;
	localparam logic [6:0] ADDR_RATE_Z_LOW = 7'h0C;
	localparam logic [6:0] ADDR_RATE_Z_HIGH = 7'h0E;
	localparam logic [6:0] ADDR_ACCEL_X_LOW = 7'h10;
	localparam logic [6:0] ADDR_ACCEL_X_HIGH = 7'h12;
	// field layout of a 32-bit sample: high word on top, low word below
	localparam int unsigned HIGH_MSB = 31;
	localparam int unsigned HIGH_LSB = 16;
	localparam int unsigned LOW_MSB = 15;
	localparam int unsigned LOW_LSB = 0;
	// value held before the first sample and on unmapped addresses
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [31:0] SAMPLE_RESET = 32'h0000_0000;
	localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
	// one sample set: all axes taken together
	typedef struct packed {
		logic [31:0] rate_x;
		logic [31:0] rate_y;
		logic [31:0] rate_z;
		logic [31:0] accel_x;
	} iod_sample_t;
	// register read request and answer
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
	} iod_rd_req_t;
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} iod_rd_rsp_t;
endpackage
`default_nettype wire

// ---- iod_axis_reg.sv ----
// iod_axis_reg.sv: one axis holding register, both words from one sample
`timescale 1ns/10ps
`default_nettype none
module iod_axis_reg #(
	parameter int unsigned W = 32
) (
	input wire logic clk, // block clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic load, // take a new sample this cycle
	input wire logic [W-1:0] sample_in, // twos complement sample
	output logic [W-1:0] sample_q // held sample, high and low words
);
	// both halves load together so a host read pair made between two loads is coherent
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_q <= '0;
		end else if (load) begin
			sample_q <= sample_in;
		end
	end
endmodule // iod_axis_reg
`default_nettype wire

// ---- iod_output_regs.sv ----
// iod_output_regs.sv: read-only rate and acceleration output registers
`timescale 1ns/10ps
`default_nettype none
module iod_output_regs (
	input wire logic mclk, // 20 MHz block clock
	input wire logic rst_b, // asynchronous reset, active low
	input wire logic sample_load, // one-cycle pulse: new sample set
	input wire iod_pkg::iod_sample_t sample_in, // sample set from datapath
	input wire iod_pkg::iod_rd_req_t rd_req, // register read request
	output iod_pkg::iod_rd_rsp_t rd_rsp // registered read answer
);
	// reset synchroniser stages
	logic rst_sync1_q;
	logic rst_sync2_q;
	// held sample set, every axis from one load
	iod_pkg::iod_sample_t held;
	// request as seen this cycle
	logic rd_take; // read accepted on this edge
	logic [6:0] rd_addr; // word address of the read
	// axis words of the held set
	logic [15:0] rx_hi; // rate x coarse word
	logic [15:0] rx_lo; // rate x fine bits
	logic [15:0] ry_hi; // rate y coarse word
	logic [15:0] ry_lo; // rate y fine bits
	logic [15:0] rz_hi; // rate z coarse word
	logic [15:0] rz_lo; // rate z fine bits
	logic [15:0] ax_hi; // accel x coarse word
	logic [15:0] ax_lo; // accel x fine bits

	// address decode, one select per output word
	logic sel_rx_lo;
	logic sel_rx_hi;
	logic sel_ry_lo;
	logic sel_ry_hi;
	logic sel_rz_lo;
	logic sel_rz_hi;
	logic sel_ax_lo;
	logic sel_ax_hi;

	// select-gated words, zero unless their address is read
	logic [15:0] term_rx_lo;
	logic [15:0] term_rx_hi;
	logic [15:0] term_ry_lo;
	logic [15:0] term_ry_hi;
	logic [15:0] term_rz_lo;
	logic [15:0] term_rz_hi;
	logic [15:0] term_ax_lo;
	logic [15:0] term_ax_hi;
	// read mux results
	logic [7:0] sel_vec; // one-hot view of the selects
	logic rd_hit; // a mapped word answers
	logic [15:0] rd_word; // or of the gated words
	logic [15:0] rd_data_d; // word to capture

	// answer flip-flops
	logic rd_valid_q;
	logic [15:0] rd_data_q;

	// reset release through two flip-flops; assertion stays asynchronous,
	// release is retimed so no holding register leaves reset on a
	// different edge from its neighbours
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	// one holding register per axis, full 32 bits in one load, so a
	// host that reads both words between loads sees one sample
	iod_axis_reg #(.W(iod_pkg::SAMPLE_W)) u_rate_x (
		.clk(mclk),
		.rst_n(rst_sync2_q),
		.load(sample_load),
		.sample_in(sample_in.rate_x),
		.sample_q(held.rate_x)
	);
	iod_axis_reg #(.W(iod_pkg::SAMPLE_W)) u_rate_y (
		.clk(mclk),
		.rst_n(rst_sync2_q),
		.load(sample_load),
		.sample_in(sample_in.rate_y),
		.sample_q(held.rate_y)
	);
	iod_axis_reg #(.W(iod_pkg::SAMPLE_W)) u_rate_z (
		.clk(mclk),
		.rst_n(rst_sync2_q),
		.load(sample_load),
		.sample_in(sample_in.rate_z),
		.sample_q(held.rate_z)
	);
	iod_axis_reg #(.W(iod_pkg::SAMPLE_W)) u_accel_x (
		.clk(mclk),
		.rst_n(rst_sync2_q),
		.load(sample_load),
		.sample_in(sample_in.accel_x),
		.sample_q(held.accel_x)
	);

	// request fields under names of their own
	assign rd_take = rd_req.valid;
	assign rd_addr = rd_req.addr;

	// address decode; only the even address of each output word answers,
	// its odd twin falls through as unmapped
	assign sel_rx_lo =
		rd_addr == iod_pkg::ADDR_RATE_X_LOW;
	assign sel_rx_hi =
		rd_addr == iod_pkg::ADDR_RATE_X_HIGH;
	assign sel_ry_lo =
		rd_addr == iod_pkg::ADDR_RATE_Y_LOW;
	assign sel_ry_hi =
		rd_addr == iod_pkg::ADDR_RATE_Y_HIGH;
	assign sel_rz_lo =
		rd_addr == iod_pkg::ADDR_RATE_Z_LOW;
	assign sel_rz_hi =
		rd_addr == iod_pkg::ADDR_RATE_Z_HIGH;
	assign sel_ax_lo =
		rd_addr == iod_pkg::ADDR_ACCEL_X_LOW;
	assign sel_ax_hi =
		rd_addr == iod_pkg::ADDR_ACCEL_X_HIGH;
	assign sel_vec = {sel_ax_hi, sel_ax_lo, sel_rz_hi, sel_rz_lo,
		sel_ry_hi, sel_ry_lo, sel_rx_hi, sel_rx_lo};
	assign rd_hit = |sel_vec; // at most one select is ever high

	// rate x: coarse twos complement word on top,
	// sixteen finer bits below it
	assign rx_hi =
		held.rate_x[iod_pkg::HIGH_MSB:iod_pkg::HIGH_LSB];
	assign rx_lo =
		held.rate_x[iod_pkg::LOW_MSB:iod_pkg::LOW_LSB];
	assign term_rx_lo = sel_rx_lo ? rx_lo : '0;
	assign term_rx_hi = sel_rx_hi ? rx_hi : '0;

	// rate y: same split; full scale words 0x4E20 and 0xB1E0
	// come out exactly as the sample carries them
	assign ry_hi =
		held.rate_y[iod_pkg::HIGH_MSB:iod_pkg::HIGH_LSB];
	assign ry_lo =
		held.rate_y[iod_pkg::LOW_MSB:iod_pkg::LOW_LSB];
	assign term_ry_lo = sel_ry_lo ? ry_lo : '0;
	assign term_ry_hi = sel_ry_hi ? ry_hi : '0;

	// rate z: the 32-bit pair steps at the coarse step over 2^16,
	// which needs nothing more than keeping both halves together
	assign rz_hi =
		held.rate_z[iod_pkg::HIGH_MSB:iod_pkg::HIGH_LSB];
	assign rz_lo =
		held.rate_z[iod_pkg::LOW_MSB:iod_pkg::LOW_LSB];
	assign term_rz_lo = sel_rz_lo ? rz_lo : '0;
	assign term_rz_hi = sel_rz_hi ? rz_hi : '0;

	// accel x: coarse word of 1.25 mg counts on top,
	// extra resolution bits below it
	assign ax_hi =
		held.accel_x[iod_pkg::HIGH_MSB:iod_pkg::HIGH_LSB];
	assign ax_lo =
		held.accel_x[iod_pkg::LOW_MSB:iod_pkg::LOW_LSB];
	assign term_ax_lo = sel_ax_lo ? ax_lo : '0;
	assign term_ax_hi = sel_ax_hi ? ax_hi : '0;

	// and-or read mux; words pass through unchanged so twos complement
	// codes such as 0x4E20, 0xB1E0, 0x7D00, 0x8300 read exactly as held
	assign rd_word = term_rx_lo |
		term_rx_hi |
		term_ry_lo |
		term_ry_hi |
		term_rz_lo |
		term_rz_hi |
		term_ax_lo |
		term_ax_hi;
	// unmapped addresses answer a fixed word
	assign rd_data_d = rd_hit ? rd_word : iod_pkg::UNMAPPED_DATA;

	// answer strobe: high for exactly one cycle after each
	// accepted request, never stretched
	always_ff @(posedge mclk or negedge rst_sync2_q) begin
		if (!rst_sync2_q) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_take;
		end
	end

	// answer word: captured on a read, held until the next one, so a
	// slow reader may still pick it up after the strobe has gone
	always_ff @(posedge mclk or negedge rst_sync2_q) begin
		if (!rst_sync2_q) begin
			rd_data_q <= iod_pkg::WORD_RESET;
		end else if (rd_take) begin
			rd_data_q <= rd_data_d;
		end
	end

	// ports come straight from the answer flip-flops
	assign rd_rsp.valid = rd_valid_q;
	assign rd_rsp.data = rd_data_q;
endmodule // iod_output_regs
`default_nettype wire

// ---- iod_output_regs_props.sv ----
// iod_output_regs_props.sv: assertions on the output register ports
`timescale 1ns/10ps
`default_nettype none
module iod_output_regs_props (
	input wire logic mclk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic sample_load, // load strobe
	input wire iod_pkg::iod_sample_t sample_in, // sample set
	input wire iod_pkg::iod_rd_req_t rd_req, // request
	input wire iod_pkg::iod_rd_rsp_t rd_rsp // answer
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [127:0] sh_q;
	logic [15:0] ex_q;
	wire v = rd_req.valid;
	wire [6:0] a = rd_req.addr;
	wire [15:0] d = rd_rsp.data;
	wire [2:0] k = 3'((a - 7'h04) >> 1);
	wire hit = !a[0] && a >= 7'h04 && a <= 7'h12;
	// shadow sample; word owed by a read, old sample on a shared edge
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sh_q <= '0;
			ex_q <= '0;
		end else begin
			if (sample_load)
				sh_q <= sample_in;
			if (v)
				ex_q <= hit ? sh_q[111 - 32 * k[2:1] + 16 * k[0] -: 16] : '0;
		end
	end
	chk_rsp_valid: assert property (v |=> rd_rsp.valid)
		else $error("no answer");
	chk_valid_pulse: assert property (!v |=> !rd_rsp.valid)
		else $error("stray answer");
	chk_x_high: assert property (v && a == 7'h06 |=> d == ex_q)
		else $error("x high");
	chk_x_low: assert property (v && a == 7'h04 |=> d == ex_q)
		else $error("x low");
	chk_y_words: assert property (v && a[6:2] == 5'h02 |=> d == ex_q)
		else $error("y");
	chk_z_words: assert property (v && a[6:2] == 5'h03 |=> d == ex_q)
		else $error("z");
	chk_acc_high: assert property (v && a == 7'h12 |=> d == ex_q)
		else $error("acc high");
	chk_acc_low: assert property (v && a == 7'h10 |=> d == ex_q)
		else $error("acc low");
	chk_unmapped: assert property (v && !hit |=> d == 16'h0000)
		else $error("unmapped");
	cover property (sample_load);
	cover property (v && a == 7'h12);
	cover property (v && !hit);
endmodule // iod_output_regs_props
bind iod_output_regs iod_output_regs_props props (.mclk(mclk), .rst_b(rst_b),
	.sample_load(sample_load), .sample_in(sample_in), .rd_req(rd_req),
	.rd_rsp(rd_rsp));
`default_nettype wire

// ---- iod_host.sv ----
// iod_host.sv: host model issuing register reads
`timescale 1ns/10ps
`default_nettype none
module iod_host (
	input wire logic mclk, // clock
	input wire iod_pkg::iod_rd_rsp_t rd_rsp, // answer
	output var iod_pkg::iod_rd_req_t rd_req // request
);
	initial rd_req = '{valid: 1'b0, addr: 7'h7F};
	// request for one edge; answer stands in the following cycle
	task automatic rd(input logic [6:0] ad, output logic ok,
		output logic [15:0] dt);
		@(posedge mclk);
		#2 rd_req = '{valid: 1'b1, addr: ad};
		@(posedge mclk);
		#2 rd_req = '{valid: 1'b0, addr: ~ad};
		ok = rd_rsp.valid;
		dt = rd_rsp.data;
	endtask
endmodule // iod_host
`default_nettype wire

// ---- iod_output_regs_test.sv ----
// iod_output_regs_test.sv: read tests of the output registers
`timescale 1ns/10ps
`default_nettype none
module iod_output_regs_test;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic sample_load = 1'b0;
	iod_pkg::iod_sample_t sample_in = '0;
	iod_pkg::iod_rd_req_t rd_req;
	iod_pkg::iod_rd_rsp_t rd_rsp;
	int error_cnt = 0;
	int n_tests = 0;
	logic ok;
	logic [15:0] dt, ew;
	logic [127:0] sets [2] = '{128'h4E200000_B1E00000_FFFFFFFF_7D000000,
		128'h00000001_0002ABCD_FFFE5678_83000000};
	always #25 mclk = ~mclk;
	iod_output_regs uut (.mclk(mclk), .rst_b(rst_b), .sample_load(sample_load),
		.sample_in(sample_in), .rd_req(rd_req), .rd_rsp(rd_rsp));
	iod_host host (.mclk(mclk), .rd_rsp(rd_rsp), .rd_req(rd_req));
	task automatic chk(input string n, input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rd_chk(input logic [6:0] ad, input logic [15:0] e);
		host.rd(ad, ok, dt);
		chk("rsp valid", 16'(ok), 16'h0001);
		chk("rsp data", dt, e);
		@(posedge mclk);
		#2 chk("rsp pulse", 16'(rd_rsp.valid), 16'h0000);
	endtask
	// reset, full scale and fine sets read word by word, then holes
	initial begin
		repeat (3) @(posedge mclk);
		#2 rst_b = 1'b1;
		repeat (3) @(posedge mclk);
		#2 chk("idle valid", 16'(rd_rsp.valid), 16'h0000);
		chk("idle data", rd_rsp.data, 16'h0000);
		rd_chk(7'h06, 16'h0000);
		foreach (sets[i]) begin
			@(posedge mclk);
			#2 sample_load = 1'b1;
			sample_in = sets[i];
			@(posedge mclk);
			#2 sample_load = 1'b0;
			sample_in = ~sets[i];
			for (int k = 0; k < 8; k++) begin
				ew = sets[i][111 - 32 * (k / 2) + 16 * (k % 2) -: 16];
				rd_chk(7'(4 + 2 * k), ew);
			end
		end
		rd_chk(7'h05, 16'h0000);
		rd_chk(7'h14, 16'h0000);
		report_and_stop();
	end
endmodule // iod_output_regs_test
`default_nettype wire
